// ---- cdar_pkg.sv ----
// constants, types and field layout for the cable diagnostic amplitude result registers
package cdar_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // field widths
    localparam int AMP_W      = 7;
    localparam int LOC_W      = 8;
    localparam int REG_W      = 16;
    localparam int ADDR_W     = 16;
    localparam int IDX_W      = 3;

    typedef logic [AMP_W-1:0] cdar_amp_t;
    typedef logic [LOC_W-1:0] cdar_loc_t;
    typedef logic [REG_W-1:0] cdar_reg_t;
    typedef logic [ADDR_W-1:0] cdar_addr_t;
    typedef logic [IDX_W-1:0] cdar_idx_t;

    ////////////////////////////////////////////////////////////////////////////////
    // register offsets
    localparam cdar_addr_t ADDR_LOCATION_RESULT_TWO   = 16'h0181;
    localparam cdar_addr_t ADDR_LOCATION_RESULT_THREE = 16'h0182;
    localparam cdar_addr_t ADDR_LOCATION_RESULT_FOUR  = 16'h0183;
    localparam cdar_addr_t ADDR_AMPLITUDE_RESULT_TWO   = 16'h0186;
    localparam cdar_addr_t ADDR_AMPLITUDE_RESULT_THREE = 16'h0187;
    localparam cdar_addr_t ADDR_AMPLITUDE_RESULT_FOUR  = 16'h0188;

    // reset values
    localparam cdar_amp_t AMP_RESET  = 7'h00;
    localparam cdar_loc_t LOC_RESET  = 8'h00;
    localparam cdar_reg_t REG_ZERO   = 16'h0000;
    localparam logic      RSVD_BIT   = 1'b0;

    ////////////////////////////////////////////////////////////////////////////////
    // peak source encodings
    localparam logic      PAIR_TRANSMIT = 1'b0;
    localparam logic      PAIR_RECEIVE  = 1'b1;
    localparam cdar_idx_t PEAK_ONE   = 3'h1;
    localparam cdar_idx_t PEAK_TWO   = 3'h2;
    localparam cdar_idx_t PEAK_THREE = 3'h3;
    localparam cdar_idx_t PEAK_FOUR  = 3'h4;
    localparam cdar_idx_t PEAK_FIVE  = 3'h5;

    // storage slots kept by this bank
    localparam int SLOT_TX3   = 0;
    localparam int SLOT_TX4   = 1;
    localparam int SLOT_TX5   = 2;
    localparam int SLOT_RX1   = 3;
    localparam int SLOT_RX2   = 4;
    localparam int SLOT_RX3   = 5;
    localparam int NUM_SLOTS  = 6;

    typedef logic [NUM_SLOTS-1:0] cdar_slot_mask_t;

endpackage

// ---- cdar_peak_slot.sv ----
// one stored peak: amplitude and its paired location
`timescale 1ns/1ps
`default_nettype none
module cdar_peak_slot #(
    parameter int AMP_W = 7,
    parameter int LOC_W = 8
) (
    // clock and reset
    input  wire logic             i_ref_clk,
    input  wire logic             i_rst,
    // control
    input  wire logic             i_clear,
    input  wire logic             i_load,
    input  wire logic [AMP_W-1:0] i_amp,
    input  wire logic [LOC_W-1:0] i_loc,
    // stored value
    output logic      [AMP_W-1:0] o_amp,
    output logic      [LOC_W-1:0] o_loc
);
    logic [AMP_W-1:0] amp_ff;
    logic [LOC_W-1:0] loc_ff;
    logic [AMP_W-1:0] nxt_amp;
    logic [LOC_W-1:0] nxt_loc;

    ////////////////////////////////////////////////////////////////////////////////
    // load beats clear so a peak reported with a restart of an open run is never dropped
    always_comb begin
        nxt_amp = amp_ff;
        nxt_loc = loc_ff;
        if (i_load) begin
            nxt_amp = i_amp;
            nxt_loc = i_loc;
        end else if (i_clear) begin
            nxt_amp = '0;
            nxt_loc = '0;
        end
    end

    // otherwise held, so results survive until the next run
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            amp_ff <= '0;
            loc_ff <= '0;
        end else begin
            amp_ff <= nxt_amp;
            loc_ff <= nxt_loc;
        end
    end

    assign o_amp = amp_ff;
    assign o_loc = loc_ff;
endmodule
`default_nettype wire

// ---- cdar_amplitude_results.sv ----
// cable diagnostic amplitude result bank with its paired peak locations
//
// Added by the designer: strobed register access.
`timescale 1ns/1ps
`default_nettype none
module cdar_amplitude_results (
    // clock and reset
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_rst,
    // reflectometry engine
    input  wire logic                 i_run_start,
    input  wire logic                 i_run_done,
    input  wire logic                 i_peak_valid,
    input  wire logic                 i_peak_pair,
    input  wire cdar_pkg::cdar_idx_t  i_peak_index,
    input  wire cdar_pkg::cdar_amp_t  i_peak_amp,
    input  wire cdar_pkg::cdar_loc_t  i_peak_loc,
    // register port
    input  wire cdar_pkg::cdar_addr_t i_addr,
    input  wire cdar_pkg::cdar_reg_t  i_wdata,
    input  wire logic                 i_wr,
    input  wire logic                 i_rd,
    output logic                      o_rvalid,
    output cdar_pkg::cdar_reg_t       o_rdata,
    // status
    output logic                      o_results_valid,
    output logic                      o_running
);
    import cdar_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // register map, all words read-only
    //   amplitude_result_two   : tx peak four upper, tx peak three lower
    //   amplitude_result_three : rx peak one upper, tx peak five lower
    //   amplitude_result_four  : rx peak three upper, rx peak two lower
    //   location_result_two    : locations paired with amplitude_result_two
    //   location_result_three  : locations paired with amplitude_result_three
    //   location_result_four   : locations paired with amplitude_result_four
    // amplitude words hold two 7-bit fields, each with a spare zero bit above it;
    // location words hold two 8-bit fields and have no spare bits
    //
    // engine side, all strobes one cycle wide and on this clock
    //   start clears every kept slot and opens a run, from any state
    //   peak reports land in their slot only while a run is open
    //   done closes the run and raises the results-valid level
    //   start wins over a done in the same cycle
    //   tx peaks one and two and rx peaks four and five belong to other banks,
    //   so they are dropped here, as are peak numbers outside one to five
    //
    // limitations and trade-offs
    //   words read back whatever is stored, valid or not; software watches
    //   the results-valid level before it trusts them
    //   a restart of an open run with a peak in the same cycle keeps that peak, trading a
    //   possibly stale value against losing a report sent with the restart
    //   writes are accepted and dropped with no error reply, so a stray write
    //   can never disturb a finished result set
    //   reads never stall: the answer always stands in the cycle after the strobe
    //   an unmapped read answers zero with valid high
    //   every result word and both status levels clear on the synchronous reset
    //   no synchroniser on the engine strobes: the engine shares this clock

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} cdar_state_e;

    ////////////////////////////////////////////////////////////////////////////////
    // decoding helpers

    // which kept slot a reported peak lands in; peaks outside this bank hit none
    // a one-hot mask lets the slot loop take one load bit per slot
    function automatic cdar_slot_mask_t slot_of(input logic pair, input cdar_idx_t idx);
        cdar_slot_mask_t m;
        m = '0;
        if (pair == PAIR_TRANSMIT) begin
            if (idx == PEAK_THREE) m[SLOT_TX3] = 1'b1;
            if (idx == PEAK_FOUR)  m[SLOT_TX4] = 1'b1;
            if (idx == PEAK_FIVE)  m[SLOT_TX5] = 1'b1;
        end else begin
            if (idx == PEAK_ONE)   m[SLOT_RX1] = 1'b1;
            if (idx == PEAK_TWO)   m[SLOT_RX2] = 1'b1;
            if (idx == PEAK_THREE) m[SLOT_RX3] = 1'b1;
        end
        return m;
    endfunction

    // two amplitudes into one word with reserved bits 15 and 7 forced low
    // spare bits are forced here, so no stored value can ever reach them
    function automatic cdar_reg_t pack_amp(input cdar_amp_t upper, input cdar_amp_t lower);
        return {RSVD_BIT, upper, RSVD_BIT, lower};
    endfunction

    // two locations into one word, upper in 15:8 and lower in 7:0
    function automatic cdar_reg_t pack_loc(input cdar_loc_t upper, input cdar_loc_t lower);
        return {upper, lower};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // run tracking

    cdar_state_e state_ff;
    cdar_state_e nxt_state;
    logic        valid_ff;
    logic        nxt_valid;
    logic        running_ff;
    logic        nxt_running;

    // a start always restarts, even mid-run; done only counts while running
    // done outside a run is ignored, so a late done cannot validate a cleared set
    // both status levels come from the next state and are registered beside it,
    // so they change on the same edge as the state
    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            ST_IDLE: begin
                if (i_run_start) nxt_state = ST_RUN;
            end
            ST_RUN: begin
                if (i_run_start) nxt_state = ST_RUN;
                else if (i_run_done) nxt_state = ST_DONE;
            end
            ST_DONE: begin
                if (i_run_start) nxt_state = ST_RUN;
            end
        endcase
        nxt_valid   = (nxt_state == ST_DONE);
        nxt_running = (nxt_state == ST_RUN);
    end

    // register only; the synchronous reset returns to idle with both levels low
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_ff   <= ST_IDLE;
            valid_ff   <= 1'b0;
            running_ff <= 1'b0;
        end else begin
            state_ff   <= nxt_state;
            valid_ff   <= nxt_valid;
            running_ff <= nxt_running;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // result storage

    cdar_slot_mask_t hit;
    logic            clear_all;
    cdar_amp_t       amp   [NUM_SLOTS];
    cdar_loc_t       loc   [NUM_SLOTS];

    // peaks are taken only during a run, so finished results cannot drift
    assign hit       = (state_ff == ST_RUN && i_peak_valid) ?
                       slot_of(i_peak_pair, i_peak_index) : '0;
    // a start clears every slot at once; a peak sent with it still loads if a run is already open
    assign clear_all = i_run_start;

    // one slot per kept peak; all share the engine data and differ only in load
    generate
        for (genvar s = 0; s < NUM_SLOTS; s++) begin : g_slot
            cdar_peak_slot #(
                .AMP_W (AMP_W),
                .LOC_W (LOC_W)
            ) u_slot (
                .i_ref_clk (i_ref_clk),
                .i_rst     (i_rst),
                .i_clear   (clear_all),
                .i_load    (hit[s]),
                .i_amp     (i_peak_amp),
                .i_loc     (i_peak_loc),
                .o_amp     (amp[s]),
                .o_loc     (loc[s])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // register read port

    cdar_reg_t rdata_ff;
    cdar_reg_t nxt_rdata;
    logic      rvalid_ff;
    logic      nxt_rvalid;

    // every register is read-only: writes are dropped and i_wdata is never stored;
    // unmapped reads return zero; data stands only in the cycle after the strobe
    // the word is zero in every cycle without an answer, so an or-tree can merge it
    // amplitude and location words share one decode, so a pair reads the same slots
    always_comb begin
        nxt_rdata  = REG_ZERO;
        nxt_rvalid = i_rd;
        if (i_rd) begin
            unique case (i_addr)
                ADDR_AMPLITUDE_RESULT_TWO:
                    nxt_rdata = pack_amp(amp[SLOT_TX4], amp[SLOT_TX3]);
                ADDR_AMPLITUDE_RESULT_THREE:
                    nxt_rdata = pack_amp(amp[SLOT_RX1], amp[SLOT_TX5]);
                ADDR_AMPLITUDE_RESULT_FOUR:
                    nxt_rdata = pack_amp(amp[SLOT_RX3], amp[SLOT_RX2]);
                ADDR_LOCATION_RESULT_TWO:
                    nxt_rdata = pack_loc(loc[SLOT_TX4], loc[SLOT_TX3]);
                ADDR_LOCATION_RESULT_THREE:
                    nxt_rdata = pack_loc(loc[SLOT_RX1], loc[SLOT_TX5]);
                ADDR_LOCATION_RESULT_FOUR:
                    nxt_rdata = pack_loc(loc[SLOT_RX3], loc[SLOT_RX2]);
                default:
                    nxt_rdata = REG_ZERO;
            endcase
        end
    end

    // data and valid leave flip-flops: a fixed one-cycle read latency, no stalls
    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            rdata_ff  <= REG_ZERO;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    // every output comes straight from its flip-flop
    assign o_rdata         = rdata_ff;
    assign o_rvalid        = rvalid_ff;
    assign o_results_valid = valid_ff;
    assign o_running       = running_ff;
endmodule
`default_nettype wire

// ---- cdar_monitor.sv ----
// bound checker for the amplitude result bank
`timescale 1ns/1ps
`default_nettype none
module cdar_monitor (
    // clock and reset
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst,
    // engine strobes
    input wire logic                 i_run_start,
    input wire logic                 i_run_done,
    // register port
    input wire cdar_pkg::cdar_addr_t i_addr,
    input wire logic                 i_rd,
    input wire logic                 o_rvalid,
    input wire cdar_pkg::cdar_reg_t  o_rdata,
    // status
    input wire logic                 o_results_valid,
    input wire logic                 o_running
);
    import cdar_pkg::*;
    logic amp_hit;
    logic mapped;
    // address decode kept outside the properties so they stay short
    assign amp_hit = i_addr inside {ADDR_AMPLITUDE_RESULT_TWO, ADDR_AMPLITUDE_RESULT_THREE,
                                    ADDR_AMPLITUDE_RESULT_FOUR};
    assign mapped  = amp_hit || i_addr inside {ADDR_LOCATION_RESULT_TWO,
                                               ADDR_LOCATION_RESULT_THREE, ADDR_LOCATION_RESULT_FOUR};
    ////////////////////////////////////////////////////////////////////////////////
    // all checks run on the one clock, quiet during reset
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (i_rst);
    a_read_answer: assert property (i_rd |=> o_rvalid)
        else $error("read strobe got no answer");
    a_quiet_port: assert property (!i_rd |=> !o_rvalid && o_rdata == 16'h0000)
        else $error("read port active without a read");
    a_rsvd_zero: assert property (i_rd && amp_hit |=> !o_rdata[15] && !o_rdata[7])
        else $error("spare amplitude bit read as one");
    a_unmapped_zero: assert property (i_rd && !mapped |=> o_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_done_valid: assert property (o_running && i_run_done && !i_run_start
        |=> o_results_valid && !o_running)
        else $error("done did not raise results valid");
    a_no_early_valid: assert property (!o_results_valid && !(o_running && i_run_done)
        |=> !o_results_valid)
        else $error("results valid without done");
    a_start_clears: assert property (i_run_start |=> o_running && !o_results_valid)
        else $error("start did not open a run");
    a_valid_holds: assert property (o_results_valid && !i_run_start |=> o_results_valid)
        else $error("results valid dropped without start");
    a_reset_clear: assert property ($fell(i_rst) |-> !o_running && !o_results_valid && !o_rvalid)
        else $error("outputs not cleared by reset");
    c_done: cover property (o_running && i_run_done);
    c_amp_read: cover property (i_rd && amp_hit);
    c_restart: cover property (o_results_valid && i_run_start);
endmodule
bind cdar_amplitude_results cdar_monitor cdar_monitor_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
    .i_run_start(i_run_start), .i_run_done(i_run_done), .i_addr(i_addr), .i_rd(i_rd),
    .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_results_valid(o_results_valid),
    .o_running(o_running));
`default_nettype wire

// ---- cdar_tb.sv ----
// self-checking bench for the amplitude result bank
`timescale 1ns/1ps
`default_nettype none
module tb;
    import cdar_pkg::*;
    logic       i_ref_clk = 1'b0, i_rst = 1'b1, i_run_start = 1'b0, i_run_done = 1'b0;
    logic       i_peak_valid = 1'b0, i_peak_pair = 1'b0, i_wr = 1'b0, i_rd = 1'b0;
    logic       o_rvalid, o_results_valid, o_running;
    cdar_idx_t  i_peak_index = 3'h0;
    cdar_amp_t  i_peak_amp = 7'h00, amp[NUM_SLOTS];
    cdar_loc_t  i_peak_loc = 8'h00, loc[NUM_SLOTS];
    cdar_addr_t i_addr = 16'h0000;
    cdar_reg_t  i_wdata = 16'h0000, o_rdata, exp_q[$];
    cdar_addr_t addrs[7] = '{16'h0186, 16'h0187, 16'h0188, 16'h0181, 16'h0182, 16'h0183, 16'h0189};
    int         errors = 0, checks = 0, seed = 29656;
    always #25 i_ref_clk = ~i_ref_clk;
    cdar_amplitude_results cdar_amplitude_results_i (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
        .i_run_start(i_run_start), .i_run_done(i_run_done), .i_peak_valid(i_peak_valid),
        .i_peak_pair(i_peak_pair), .i_peak_index(i_peak_index), .i_peak_amp(i_peak_amp),
        .i_peak_loc(i_peak_loc), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .o_rvalid(o_rvalid), .o_rdata(o_rdata), .o_results_valid(o_results_valid),
        .o_running(o_running));
    ////////////////////////////////////////////////////////////////////////////////
    // expected register image, packed from the model slots
    function automatic cdar_reg_t exp_reg(cdar_addr_t a);
        case (a)
            ADDR_AMPLITUDE_RESULT_TWO:   return {1'b0, amp[SLOT_TX4], 1'b0, amp[SLOT_TX3]};
            ADDR_AMPLITUDE_RESULT_THREE: return {1'b0, amp[SLOT_RX1], 1'b0, amp[SLOT_TX5]};
            ADDR_AMPLITUDE_RESULT_FOUR:  return {1'b0, amp[SLOT_RX3], 1'b0, amp[SLOT_RX2]};
            ADDR_LOCATION_RESULT_TWO:    return {loc[SLOT_TX4], loc[SLOT_TX3]};
            ADDR_LOCATION_RESULT_THREE:  return {loc[SLOT_RX1], loc[SLOT_TX5]};
            ADDR_LOCATION_RESULT_FOUR:   return {loc[SLOT_RX3], loc[SLOT_RX2]};
            default:                     return REG_ZERO;
        endcase
    endfunction
    task automatic close_out();
        if (errors == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(cdar_reg_t got, cdar_reg_t e);
        checks++;
        if (got !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    // each step sets every strobe exactly once, so back-to-back steps never double-assign
    task automatic tick(logic rs, logic dn, logic pv, logic wr, logic rd);
        @(posedge i_ref_clk);
        i_run_start <= rs;
        i_run_done <= dn;
        i_peak_valid <= pv;
        i_wr <= wr;
        i_rd <= rd;
    endtask
    task automatic settle();
        tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        @(negedge i_ref_clk);
    endtask
    task automatic clear_model();
        foreach (amp[i]) begin
            amp[i] = AMP_RESET;
            loc[i] = LOC_RESET;
        end
    endtask
    task automatic read_all();
        foreach (addrs[i]) begin
            tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b1);
            i_addr <= addrs[i];
            exp_q.push_back(exp_reg(addrs[i]));
        end
    endtask
    task automatic write_all();
        foreach (addrs[i]) begin
            tick(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
            i_addr <= addrs[i];
            i_wdata <= cdar_reg_t'($random(seed));
        end
    endtask
    // take says whether the bank is in a run and must keep a kept slot;
    // rs sends a restart in the same cycle, which clears the model first
    task automatic peak(logic p, cdar_idx_t x, logic take, logic rs);
        int        s;
        cdar_amp_t a;
        cdar_loc_t l;
        a = cdar_amp_t'($random(seed));
        l = cdar_loc_t'($random(seed));
        s = p ? ((x >= 3'h1 && x <= 3'h3) ? SLOT_RX1 + x - 1 : -1)
              : ((x >= 3'h3 && x <= 3'h5) ? SLOT_TX3 + x - 3 : -1);
        tick(rs, 1'b0, 1'b1, 1'b0, 1'b0);
        i_peak_pair <= p;
        i_peak_index <= x;
        i_peak_amp <= a;
        i_peak_loc <= l;
        if (rs)
            clear_model();
        if (take && s >= 0) begin
            amp[s] = a;
            loc[s] = l;
        end
    endtask
    task automatic start_run();
        tick(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
        clear_model();
        settle();
    endtask
    // answers are matched oldest first at the falling edge, where outputs have settled
    always @(negedge i_ref_clk)
        if (o_rvalid === 1'b1)
            chk(o_rdata, exp_q.size() > 0 ? exp_q.pop_front() : 16'hxxxx);
    initial begin
        #100000;
        errors++;
        close_out();
    end
    initial begin
        clear_model();
        repeat (5) @(posedge i_ref_clk);
        i_rst <= 1'b0;
        read_all();
        write_all();
        read_all();
        start_run();
        chk({15'h0000, o_running}, 16'h0001);
        for (int p = 0; p < 2; p++)
            for (int x = 0; x < 8; x++)
                peak(p[0], x[2:0], 1'b1, 1'b0);
        peak(1'b0, PEAK_FOUR, 1'b1, 1'b0);
        read_all();
        settle();
        chk({15'h0000, o_results_valid}, 16'h0000);
        tick(1'b0, 1'b1, 1'b0, 1'b0, 1'b0);
        settle();
        chk({14'h0000, o_results_valid, o_running}, 16'h0002);
        write_all();
        peak(1'b1, PEAK_TWO, 1'b0, 1'b0);
        read_all();
        settle();
        chk({15'h0000, o_results_valid}, 16'h0001);
        start_run();
        chk({15'h0000, o_results_valid}, 16'h0000);
        read_all();
        // a restart inside a run clears the set but keeps a peak sent with it
        peak(1'b0, PEAK_FIVE, 1'b1, 1'b0);
        peak(1'b1, PEAK_ONE, 1'b1, 1'b1);
        settle();
        chk({14'h0000, o_results_valid, o_running}, 16'h0001);
        read_all();
        peak(1'b0, PEAK_THREE, 1'b1, 1'b0);
        tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        i_rst <= 1'b1;
        clear_model();
        tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        i_rst <= 1'b0;
        settle();
        chk({15'h0000, o_running}, 16'h0000);
        read_all();
        repeat (3) tick(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        chk(cdar_reg_t'(exp_q.size()), REG_ZERO);
        close_out();
    end
endmodule
`default_nettype wire
